// ===== rtsr_top.sv
// Two-wire slave, register file and conversion sequencer of the temperature sensor
`timescale 1ns/100ps
module rtsr_top
  import rtsr_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR  = 7'h4c,
  parameter logic [7:0]  MAKER_CODE  = 8'h5a,  // Arbitrary value
  parameter logic [7:0]  DIE_REV     = 8'h07,  // Arbitrary value
  parameter int          TIMEOUT_CYC_P = TIMEOUT_CYC,
  parameter logic [31:0] BASE_PERIOD = 32'(BASE_PERIOD_CYC)
) (
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_nrst,
  // Two-wire bus
  input  wire logic               i_smb_clk,
  input  wire logic               i_smb_dat,
  output logic                    o_smb_dat,
  output logic                    o_smb_dat_oe,
  // Converter
  output logic                    o_conv_start,
  input  wire logic               i_conv_done,
  input  wire logic signed [9:0]  i_local_raw,
  input  wire logic signed [12:0] i_remote_raw,
  input  wire logic               i_diode_open,
  input  wire logic               i_diode_short
);

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_ADDR  = 7'b0000010,
    S_ACK   = 7'b0000100,
    S_CMD   = 7'b0001000,
    S_WDATA = 7'b0010000,
    S_RDATA = 7'b0100000,
    S_MACK  = 7'b1000000
  } rtsr_state_type;

  function automatic logic signed [12:0] lim13(input logic [7:0] w, input logic [7:0] f);
    lim13 = 13'(signed'({w, f[7:5]}));
  endfunction

  function automatic logic [1:0] fq_step(input logic [1:0] c, input logic hit);
    fq_step = !hit ? 2'd0 : ((c == FQ_DEPTH) ? c : 2'(c + 2'd1));
  endfunction

  // Bus line synchronisers
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      scl_m_q <= i_smb_clk;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= i_smb_dat;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // Register file
  logic [7:0] cfg_q, rate_q, local_over_flag_q, local_under_flag_q, remote_over_flag_q, remote_under_flag_q, ofs_w_q, ofs_f_q;
  logic [7:0] remote_over_flag_f_q, remote_under_flag_f_q, remote_crit_flag_q, local_crit_flag_q, hyst_q, filt_cfg_q;
  logic [7:0] cfg_d, rate_d, local_over_flag_d, local_under_flag_d, remote_over_flag_d, remote_under_flag_d, ofs_w_d, ofs_f_d;
  logic [7:0] remote_over_flag_f_d, remote_under_flag_f_d, remote_crit_flag_d, local_crit_flag_d, hyst_d, filt_cfg_d;
  // Results
  logic [7:0]         loc_q, loc_d;
  logic signed [12:0] rem_q, rem_d;
  logic [6:0]         stat_q, stat_d;
  logic               busy_q, busy_d, start_q, start_d;

  logic [7:0] rem_whole, rem_frac, rd_byte, sel_q, sel_d;
  logic signed [12:0] rem_under;
  assign rem_under = REM_FLOOR - rem_q;
  always_comb begin
    if (rem_q < REM_FLOOR) begin
      rem_whole = WHOLE_MIN;
      rem_frac  = {rem_under[FRAC_BITS-1:0], 5'h00};
    end else begin
      rem_whole = rem_q[10:3];
      rem_frac  = {rem_q[FRAC_BITS-1:0], 5'h00};
    end
  end

  // Read data mux; undefined and write-only selectors read zero
  always_comb begin
    case (sel_q)
      RD_LOCAL:   rd_byte = loc_q;
      RD_RWHOLE:  rd_byte = rem_whole;
      RD_STATUS:  rd_byte = {busy_q, stat_q};
      RD_CFG:     rd_byte = cfg_q;
      RD_RATE:    rd_byte = rate_q;
      RD_LOCAL_OVER_FLAG:   rd_byte = local_over_flag_q;
      RD_LOCAL_UNDER_FLAG:    rd_byte = local_under_flag_q;
      RD_REMOTE_OVER_FLAG:   rd_byte = remote_over_flag_q;
      RD_REMOTE_UNDER_FLAG:    rd_byte = remote_under_flag_q;
      RD_RFRAC:   rd_byte = rem_frac;
      AD_ROFS_W:  rd_byte = ofs_w_q;
      AD_ROFS_F:  rd_byte = ofs_f_q;
      AD_REMOTE_OVER_FLAG_F: rd_byte = remote_over_flag_f_q;
      AD_REMOTE_UNDER_FLAG_F:  rd_byte = remote_under_flag_f_q;
      AD_REMOTE_CRIT_FLAG:   rd_byte = remote_crit_flag_q;
      AD_LOCAL_CRIT_FLAG:   rd_byte = local_crit_flag_q;
      AD_HYST:    rd_byte = hyst_q;
      AD_FILTER:  rd_byte = filt_cfg_q;
      RD_MAKER:   rd_byte = MAKER_CODE;
      RD_DIEREV:  rd_byte = DIE_REV;
      default:    rd_byte = RST_ZERO;
    endcase
  end

  // Bus slave
  rtsr_state_type st_q, st_d, nxt_q, nxt_d;
  logic [2:0]  bitcnt_q, bitcnt_d;
  logic [7:0]  shreg_q, shreg_d, byte_in, wr_data;
  logic        oe_q, oe_d, ackph_q, ackph_d, wr_en;
  logic [31:0] lowcnt_q, lowcnt_d;
  logic        timeout;

  assign byte_in = {shreg_q[6:0], sda_s_q};
  assign timeout = (lowcnt_q == 32'(TIMEOUT_CYC_P));

  always_comb begin
    st_d     = st_q;
    nxt_d    = nxt_q;
    bitcnt_d = bitcnt_q;
    shreg_d  = shreg_q;
    sel_d    = sel_q;
    oe_d     = oe_q;
    ackph_d  = ackph_q;
    wr_en    = 1'b0;
    wr_data  = byte_in;
    if (scl_s_q && sda_s_q) begin
      lowcnt_d = '0;
    end else begin
      lowcnt_d = timeout ? lowcnt_q : 32'(lowcnt_q + 32'd1);
    end
    if (timeout) begin
      st_d     = S_IDLE;
      oe_d     = 1'b0;
      lowcnt_d = '0;
    end else if (start_det) begin
      st_d     = S_ADDR;
      bitcnt_d = '0;
      oe_d     = 1'b0;
    end else if (stop_det) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        S_ADDR, S_CMD, S_WDATA: begin
          shreg_d  = byte_in;
          bitcnt_d = 3'(bitcnt_q + 3'd1);
          if (bitcnt_q == 3'd7) begin
            st_d    = S_ACK;
            ackph_d = 1'b0;
            case (st_q)
              S_ADDR: begin
                if (byte_in[7:1] != SLAVE_ADDR) begin
                  st_d = S_IDLE;
                end
                nxt_d = byte_in[0] ? S_RDATA : S_CMD;
              end
              S_CMD: begin
                sel_d = byte_in;
                nxt_d = S_WDATA;
              end
              default: begin
                wr_en = 1'b1;
                nxt_d = S_WDATA;
              end
            endcase
          end
        end
        S_RDATA: begin
          bitcnt_d = 3'(bitcnt_q + 3'd1);
          if (bitcnt_q == 3'd7) begin
            st_d = S_MACK;
          end
        end
        S_MACK: begin
          if (!sda_s_q) begin
            st_d    = S_ACK;
            ackph_d = 1'b1;
            nxt_d   = S_RDATA;
          end else begin
            st_d = S_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_q)
        S_ACK: begin
          if (!ackph_q) begin
            oe_d    = 1'b1;
            ackph_d = 1'b1;
          end else begin
            ackph_d  = 1'b0;
            bitcnt_d = '0;
            st_d     = nxt_q;
            if (nxt_q == S_RDATA) begin
              shreg_d = {rd_byte[6:0], 1'b0};
              oe_d    = ~rd_byte[7];
            end else begin
              oe_d = 1'b0;
            end
          end
        end
        S_RDATA: begin
          if (bitcnt_q != 3'd0) begin
            oe_d    = ~shreg_q[7];
            shreg_d = {shreg_q[6:0], 1'b0};
          end
        end
        S_MACK: oe_d = 1'b0;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_q     <= S_IDLE;
      nxt_q    <= S_IDLE;
      bitcnt_q <= '0;
      shreg_q  <= '0;
      sel_q    <= RD_LOCAL;
      oe_q     <= 1'b0;
      ackph_q  <= 1'b0;
      lowcnt_q <= '0;
    end else begin
      st_q     <= st_d;
      nxt_q    <= nxt_d;
      bitcnt_q <= bitcnt_d;
      shreg_q  <= shreg_d;
      sel_q    <= sel_d;
      oe_q     <= oe_d;
      ackph_q  <= ackph_d;
      lowcnt_q <= lowcnt_d;
    end
  end

  assign o_smb_dat    = 1'b0;
  assign o_smb_dat_oe = oe_q;

  // Register writes; read-only selectors fall through unchanged
  logic oneshot_req;
  assign oneshot_req = wr_en && (sel_q == AD_ONESHOT) && cfg_q[CFG_STBY];

  always_comb begin
    {cfg_d, rate_d, local_over_flag_d, local_under_flag_d, remote_over_flag_d, remote_under_flag_d, ofs_w_d, ofs_f_d} =
      {cfg_q, rate_q, local_over_flag_q, local_under_flag_q, remote_over_flag_q, remote_under_flag_q, ofs_w_q, ofs_f_q};
    {remote_over_flag_f_d, remote_under_flag_f_d, remote_crit_flag_d, local_crit_flag_d, hyst_d, filt_cfg_d} =
      {remote_over_flag_f_q, remote_under_flag_f_q, remote_crit_flag_q, local_crit_flag_q, hyst_q, filt_cfg_q};
    if (wr_en) begin
      case (sel_q)
        WR_CFG:     cfg_d      = wr_data & MSK_CFG;
        WR_RATE:    rate_d     = wr_data;
        WR_LOCAL_OVER_FLAG:   local_over_flag_d    = wr_data;
        WR_LOCAL_UNDER_FLAG:    local_under_flag_d     = wr_data;
        WR_REMOTE_OVER_FLAG:   remote_over_flag_d    = wr_data;
        WR_REMOTE_UNDER_FLAG:    remote_under_flag_d     = wr_data;
        AD_ROFS_W:  ofs_w_d    = wr_data;
        AD_ROFS_F:  ofs_f_d    = wr_data & MSK_FRAC;
        AD_REMOTE_OVER_FLAG_F: remote_over_flag_f_d  = wr_data & MSK_FRAC;
        AD_REMOTE_UNDER_FLAG_F:  remote_under_flag_f_d   = wr_data & MSK_FRAC;
        AD_REMOTE_CRIT_FLAG:   remote_crit_flag_d    = wr_data;
        AD_LOCAL_CRIT_FLAG:   local_crit_flag_d    = wr_data;
        AD_HYST:    hyst_d     = wr_data & MSK_HYST;
        AD_FILTER:  filt_cfg_d = wr_data & MSK_FILTER;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      {cfg_q, local_under_flag_q, remote_under_flag_q, ofs_w_q, ofs_f_q} <= {5{RST_ZERO}};
      {remote_over_flag_f_q, remote_under_flag_f_q, filt_cfg_q}         <= {3{RST_ZERO}};
      rate_q  <= RST_RATE;
      local_over_flag_q <= RST_LOCAL_OVER_FLAG;
      remote_over_flag_q <= RST_REMOTE_OVER_FLAG;
      remote_crit_flag_q <= RST_REMOTE_CRIT_FLAG;
      local_crit_flag_q <= RST_LOCAL_CRIT_FLAG;
      hyst_q  <= RST_HYST;
    end else begin
      {cfg_q, rate_q, local_over_flag_q, local_under_flag_q, remote_over_flag_q, remote_under_flag_q, ofs_w_q, ofs_f_q} <=
        {cfg_d, rate_d, local_over_flag_d, local_under_flag_d, remote_over_flag_d, remote_under_flag_d, ofs_w_d, ofs_f_d};
      {remote_over_flag_f_q, remote_under_flag_f_q, remote_crit_flag_q, local_crit_flag_q, hyst_q, filt_cfg_q} <=
        {remote_over_flag_f_d, remote_under_flag_f_d, remote_crit_flag_d, local_crit_flag_d, hyst_d, filt_cfg_d};
    end
  end

  // Conversion sequencer and result processing
  logic [31:0]        per_q, per_d, period;
  logic [3:0]         rate_eff;
  logic signed [16:0] filt_q, filt_d, tgt, filt_nx;
  logic               filt_ok_q, filt_ok_d;
  logic [1:0]         chi_q, chi_d, clo_q, clo_d, ccr_q, ccr_d;
  logic signed [12:0] adj, fout, rem_n, remote_crit_flag_v, remote_crit_flag_clr;
  logic signed [9:0]  local_crit_flag_clr;
  logic [7:0]         loc_n;
  logic               fq_on, rhit_hi, rhit_lo, rhit_cr, lhit_cr;

  assign rate_eff  = (rate_q > 8'(RATE_MAX)) ? RATE_MAX : rate_q[3:0];
  assign period    = BASE_PERIOD << (RATE_MAX - rate_eff);
  assign fq_on     = cfg_q[CFG_FQ];
  // Offset is added before filtering so the filter sees the final scale
  assign adj       = i_remote_raw - JUNC_SHIFT + lim13(ofs_w_q, ofs_f_q);
  assign tgt       = 17'(adj) <<< FILT_FRAC;
  assign remote_crit_flag_v   = 13'(signed'({remote_crit_flag_q, 3'b000}));
  assign remote_crit_flag_clr = remote_crit_flag_v - 13'({hyst_q, 3'b000});
  assign local_crit_flag_clr = 10'(signed'(local_crit_flag_q)) - 10'(hyst_q);

  // Rounded fixed-point IIR so smoothing adds no bias
  always_comb begin
    if (filt_cfg_q[FLT_HI:FLT_LO] == FLT_NONE || !filt_ok_q) begin
      filt_nx = tgt;
    end else if (filt_cfg_q[FLT_HI:FLT_LO] == FLT_LVL2) begin
      filt_nx = filt_q + ((tgt - filt_q) >>> 2);
    end else begin
      filt_nx = filt_q + ((tgt - filt_q) >>> 1);
    end
    fout = 13'((filt_nx + 17'sd8) >>> FILT_FRAC);
  end

  always_comb begin
    if (i_diode_open) begin
      rem_n = REM_OPEN;
    end else if (i_diode_short) begin
      rem_n = REM_FLOOR;
    end else if (fout > REM_MAX) begin
      rem_n = REM_MAX;
    end else if (fout < REM_MIN) begin
      rem_n = REM_MIN;
    end else begin
      rem_n = fout;
    end
    if (i_local_raw > LOC_MAX) begin
      loc_n = LOC_MAX[7:0];
    end else if (i_local_raw < LOC_MIN) begin
      loc_n = LOC_MIN[7:0];
    end else begin
      loc_n = i_local_raw[7:0];
    end
  end

  assign rhit_hi = rem_n > lim13(remote_over_flag_q, remote_over_flag_f_q);
  assign rhit_lo = rem_n < lim13(remote_under_flag_q, remote_under_flag_f_q);
  assign rhit_cr = rem_n > remote_crit_flag_v;
  assign lhit_cr = signed'(loc_n) > signed'(local_crit_flag_q);

  always_comb begin
    per_d     = per_q;
    start_d   = 1'b0;
    busy_d    = busy_q;
    filt_d    = filt_q;
    filt_ok_d = filt_ok_q;
    loc_d     = loc_q;
    rem_d     = rem_q;
    stat_d    = stat_q;
    {chi_d, clo_d, ccr_d} = {chi_q, clo_q, ccr_q};
    if (per_q != 32'd0) begin
      per_d = 32'(per_q - 32'd1);
    end
    if (!busy_q && (oneshot_req || (!cfg_q[CFG_STBY] && per_q == 32'd0))) begin
      start_d = 1'b1;
      busy_d  = 1'b1;
      if (!cfg_q[CFG_STBY]) begin
        per_d = 32'(period - 32'd1);
      end
    end else if (busy_q && i_conv_done) begin
      busy_d = 1'b0;
      loc_d  = loc_n;
      rem_d  = rem_n;
      if (!i_diode_open && !i_diode_short) begin
        filt_d    = filt_nx;
        filt_ok_d = 1'b1;
      end
      chi_d = fq_step(chi_q, rhit_hi);
      clo_d = fq_step(clo_q, rhit_lo);
      ccr_d = fq_step(ccr_q, rhit_cr);
      stat_d[ST_REMOTE_OVER_FLAG] = fq_on ? (chi_d == FQ_DEPTH) : rhit_hi;
      stat_d[ST_REMOTE_UNDER_FLAG]  = fq_on ? (clo_d == FQ_DEPTH) : rhit_lo;
      // Critical flags hold until the reading falls by the hysteresis
      if (fq_on ? (ccr_d == FQ_DEPTH) : rhit_cr) begin
        stat_d[ST_REMOTE_CRIT_FLAG] = 1'b1;
      end else if (rem_n <= remote_crit_flag_clr) begin
        stat_d[ST_REMOTE_CRIT_FLAG] = 1'b0;
      end
      if (lhit_cr) begin
        stat_d[ST_LOCAL_CRIT_FLAG] = 1'b1;
      end else if (signed'({loc_n[7], loc_n[7], loc_n}) <= local_crit_flag_clr) begin
        stat_d[ST_LOCAL_CRIT_FLAG] = 1'b0;
      end
      stat_d[ST_LOCAL_OVER_FLAG] = signed'(loc_n) > signed'(local_over_flag_q);
      stat_d[ST_LOCAL_UNDER_FLAG]  = signed'(loc_n) < signed'(local_under_flag_q);
      stat_d[ST_OPEN]  = i_diode_open;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      per_q     <= '0;
      start_q   <= 1'b0;
      busy_q    <= 1'b0;
      filt_q    <= '0;
      filt_ok_q <= 1'b0;
      loc_q     <= RST_ZERO;
      rem_q     <= '0;
      stat_q    <= '0;
      {chi_q, clo_q, ccr_q} <= '0;
    end else begin
      per_q     <= per_d;
      start_q   <= start_d;
      busy_q    <= busy_d;
      filt_q    <= filt_d;
      filt_ok_q <= filt_ok_d;
      loc_q     <= loc_d;
      rem_q     <= rem_d;
      stat_q    <= stat_d;
      {chi_q, clo_q, ccr_q} <= {chi_d, clo_d, ccr_d};
    end
  end

  assign o_conv_start = start_q;

  // Checks
  property p_timeout;
    @(posedge i_mclk) disable iff (!i_nrst) timeout |=> st_q == S_IDLE && !o_smb_dat_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("bus timeout not taken");

  property p_start;
    @(posedge i_mclk) disable iff (!i_nrst)
      (start_det && !timeout) |=> st_q == S_ADDR && bitcnt_q == 3'd0;
  endproperty
  a_start: assert property (p_start) else $error("start not honoured");

  property p_cmd;
    @(posedge i_mclk) disable iff (!i_nrst)
      (st_q == S_CMD && scl_rise && bitcnt_q == 3'd7 && !start_det && !stop_det && !timeout)
      |=> sel_q == $past(byte_in);
  endproperty
  a_cmd: assert property (p_cmd) else $error("selector not latched");

  property p_fq;
    @(posedge i_mclk) disable iff (!i_nrst)
      ($rose(stat_q[ST_REMOTE_OVER_FLAG]) && $past(fq_on)) |-> chi_q == FQ_DEPTH;
  endproperty
  a_fq: assert property (p_fq) else $error("remote high flag before three samples");

  property p_oneshot;
    @(posedge i_mclk) disable iff (!i_nrst)
      (oneshot_req && !busy_q) |=> o_conv_start && busy_q ##1 !o_conv_start;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("trigger did not start one cycle");

  property p_trig_read;
    @(posedge i_mclk) disable iff (!i_nrst) sel_q == AD_ONESHOT |-> rd_byte == RST_ZERO;
  endproperty
  a_trig_read: assert property (p_trig_read) else $error("trigger read not zero");

  property p_frac;
    @(posedge i_mclk) disable iff (!i_nrst) rem_frac[4:0] == 5'h00;
  endproperty
  a_frac: assert property (p_frac) else $error("fraction low bits set");

  property p_sat;
    @(posedge i_mclk) disable iff (!i_nrst) rem_q <= REM_MAX && rem_q >= REM_MIN;
  endproperty
  a_sat: assert property (p_sat) else $error("remote result out of range");

  property p_open;
    @(posedge i_mclk) disable iff (!i_nrst)
      (busy_q && i_conv_done && i_diode_open && !oneshot_req)
      |=> rem_whole == 8'h7f && rem_frac == RST_ZERO && stat_q[ST_OPEN];
  endproperty
  a_open: assert property (p_open) else $error("open diode result wrong");

  property p_busy;
    @(posedge i_mclk) disable iff (!i_nrst) o_conv_start |-> busy_q && !$past(busy_q);
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown during conversion");

endmodule // rtsr_top

// ===== rtsr_pkg.sv
// Constants, register map and timing for the remote temperature sensor register block
package rtsr_pkg;

  // Read selectors
  localparam logic [7:0] RD_LOCAL   = 8'h00;
  localparam logic [7:0] RD_RWHOLE  = 8'h01;
  localparam logic [7:0] RD_STATUS  = 8'h02;
  localparam logic [7:0] RD_CFG     = 8'h03;
  localparam logic [7:0] RD_RATE    = 8'h04;
  localparam logic [7:0] RD_LOCAL_OVER_FLAG   = 8'h05;
  localparam logic [7:0] RD_LOCAL_UNDER_FLAG    = 8'h06;
  localparam logic [7:0] RD_REMOTE_OVER_FLAG   = 8'h07;
  localparam logic [7:0] RD_REMOTE_UNDER_FLAG    = 8'h08;
  localparam logic [7:0] RD_RFRAC   = 8'h10;
  localparam logic [7:0] RD_MAKER   = 8'hfe;
  localparam logic [7:0] RD_DIEREV  = 8'hff;
  // Write selectors
  localparam logic [7:0] WR_CFG     = 8'h09;
  localparam logic [7:0] WR_RATE    = 8'h0a;
  localparam logic [7:0] WR_LOCAL_OVER_FLAG   = 8'h0b;
  localparam logic [7:0] WR_LOCAL_UNDER_FLAG    = 8'h0c;
  localparam logic [7:0] WR_REMOTE_OVER_FLAG   = 8'h0d;
  localparam logic [7:0] WR_REMOTE_UNDER_FLAG    = 8'h0e;
  // Shared read/write selectors; AD_ONESHOT is write-only and reads zero
  localparam logic [7:0] AD_ONESHOT = 8'h0f;
  localparam logic [7:0] AD_ROFS_W  = 8'h11;
  localparam logic [7:0] AD_ROFS_F  = 8'h12;
  localparam logic [7:0] AD_REMOTE_OVER_FLAG_F = 8'h13;
  localparam logic [7:0] AD_REMOTE_UNDER_FLAG_F  = 8'h14;
  localparam logic [7:0] AD_REMOTE_CRIT_FLAG   = 8'h19;
  localparam logic [7:0] AD_LOCAL_CRIT_FLAG   = 8'h20;
  localparam logic [7:0] AD_HYST    = 8'h21;
  localparam logic [7:0] AD_FILTER  = 8'hbf;

  // Reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_RATE   = 8'h08;
  localparam logic [7:0] RST_LOCAL_OVER_FLAG  = 8'h46;
  localparam logic [7:0] RST_REMOTE_OVER_FLAG  = 8'h46;
  localparam logic [7:0] RST_REMOTE_CRIT_FLAG  = 8'h6e;
  localparam logic [7:0] RST_LOCAL_CRIT_FLAG  = 8'h55;
  localparam logic [7:0] RST_HYST   = 8'h0a;

  // Writable bit masks
  localparam logic [7:0] MSK_CFG    = 8'hd5;
  localparam logic [7:0] MSK_FRAC   = 8'he0;
  localparam logic [7:0] MSK_HYST   = 8'h1f;
  localparam logic [7:0] MSK_FILTER = 8'h07;

  // Field positions
  localparam int CFG_FQ   = 0;
  localparam int CFG_STBY = 6;
  localparam int FLT_LO   = 1;
  localparam int FLT_HI   = 2;
  localparam int ST_LOCAL_CRIT_FLAG = 0;
  localparam int ST_REMOTE_CRIT_FLAG = 1;
  localparam int ST_OPEN  = 2;
  localparam int ST_REMOTE_UNDER_FLAG  = 3;
  localparam int ST_REMOTE_OVER_FLAG = 4;
  localparam int ST_LOCAL_UNDER_FLAG  = 5;
  localparam int ST_LOCAL_OVER_FLAG = 6;
  localparam int ST_BUSY  = 7;

  // Temperature arithmetic, remote values in eighths of a degree
  localparam int              FRAC_BITS  = 3;
  localparam int              FILT_FRAC  = 4;
  localparam logic signed [12:0] JUNC_SHIFT = 13'sd128;
  localparam logic signed [12:0] REM_MAX    = 13'sd1023;
  localparam logic signed [12:0] REM_MIN    = -13'sd1031;
  localparam logic signed [12:0] REM_FLOOR  = -13'sd1024;
  localparam logic signed [12:0] REM_OPEN   = 13'sd1016;
  localparam logic signed [9:0]  LOC_MAX    = 10'sd127;
  localparam logic signed [9:0]  LOC_MIN    = -10'sd128;
  localparam logic [7:0]         WHOLE_MIN  = 8'h80;
  localparam logic [1:0]         FQ_DEPTH   = 2'd3;
  localparam logic [1:0]         FLT_LVL2   = 2'b11;
  localparam logic [1:0]         FLT_NONE   = 2'b00;
  localparam logic [3:0]         RATE_MAX   = 4'd9;

  // Timing
  localparam int CLK_KHZ         = 250000;
  localparam int TIMEOUT_MS      = 35;
  localparam int TIMEOUT_CYC     = TIMEOUT_MS * CLK_KHZ;
  localparam int BASE_CONV_HZ    = 32;
  localparam int BASE_PERIOD_CYC = CLK_KHZ * 1000 / BASE_CONV_HZ;

endpackage

// ===== rtsr_host.sv
// Bus master model for the sensor's two-wire slave port
`timescale 1ns/100ps
module rtsr_host (
  // Clock
  input  wire logic i_mclk,
  // Two-wire bus, data open drain
  input  wire logic i_sda,
  output logic      o_scl    = 1'b1,
  output logic      o_sda_oe = 1'b0
);
  // One quarter of the 80 ns bus period
  task automatic st(input logic c, input logic d);
    o_scl    = c;
    o_sda_oe = d;
    repeat (5) @(negedge i_mclk);
  endtask
  task automatic start();
    st(1'b0, o_sda_oe);
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask
  task automatic stop();
    st(1'b0, o_sda_oe);
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
  endtask
  // Data moves only while the clock is low, else it reads as start or stop
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      st(1'b0, o_sda_oe);
      st(1'b0, ~v[i]);
      st(1'b1, ~v[i]);
      st(1'b1, ~v[i]);
      r[i] = i_sda;
    end
  endtask
endmodule // rtsr_host

// ===== tb_remote_temp_sensor_regs.sv
// Self-checking bench for the temperature sensor register block
`timescale 1ns/100ps
module tb_remote_temp_sensor_regs;
  logic               clk;
  logic               nrst;
  logic               done  = 1'b0;
  logic               dopen = 1'b0;
  logic               dshort = 1'b0;
  logic               odat;
  logic               cstart;
  logic               oe;
  logic               scl;
  logic               moe;
  logic signed [9:0]  lr = 10'sd25;
  logic signed [12:0] rr = 13'sd528;
  logic [7:0]         rx;
  logic [8:0]         r9;
  logic [15:0]        e;
  logic [7:0]         exp_q[$];
  int                 error_cnt  = 0;
  int                 num_checks = 0;
  int                 seed = 32'h1040;
  event               got;
  // Open drain: the device value only counts while its enable is up
  wire                sda = (oe ? odat : 1'b1) & ~moe;
  localparam logic [151:0] RA = {8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0f,
    8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'hbf, 8'h00, 8'h01, 8'h02};
  localparam logic [151:0] RV = {8'h40, 8'h08, 8'h46, 8'h00, 8'h46, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h6e, 8'h55, 8'h0a, 8'h00, 8'h19, 8'h32, 8'h00};
  rtsr_top #(.TIMEOUT_CYC_P(2000), .BASE_PERIOD(32'd500)) DUT (.i_mclk(clk), .i_nrst(nrst),
    .i_smb_clk(scl), .i_smb_dat(sda), .o_smb_dat(odat), .o_smb_dat_oe(oe),
    .o_conv_start(cstart), .i_conv_done(done), .i_local_raw(lr), .i_remote_raw(rr),
    .i_diode_open(dopen), .i_diode_short(dshort));
  rtsr_host host (.i_mclk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(moe));
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic chk_oe(input logic g, input logic x);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %0t ns: data enable %b, expected %b", $time, g, x);
    end
  endtask
  task automatic wreg(input logic [7:0] c, input logic [7:0] d);
    host.start();
    host.xfer({8'h98, 1'b1}, r9);
    host.xfer({c, 1'b1}, r9);
    host.xfer({d, 1'b1}, r9);
    host.stop();
  endtask
  // Without cmd the latched selector is read
  task automatic rreg(input logic [7:0] c, input logic [7:0] x, input logic cmd = 1'b1);
    exp_q.push_back(x);
    if (cmd) begin
      host.start();
      host.xfer({8'h98, 1'b1}, r9);
      host.xfer({c, 1'b1}, r9);
    end
    host.start();
    host.xfer({8'h99, 1'b1}, r9);
    host.xfer(9'h1ff, r9);
    rx = r9[8:1];
    -> got;
    host.stop();
  endtask
  task automatic conv();
    wreg(8'h0f, 8'($random(seed)));
    repeat (60) @(negedge clk);
  endtask
  function automatic logic [15:0] rem_exp(input int raw);
    int t;
    t = raw - 128;
    if (t > 1023) t = 1023;
    return {t[10:3], t[2:0], 5'h00};
  endfunction
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(got) begin
    chk(rx, exp_q.pop_front());
  end
  // Converter answers each start after 20 cycles
  initial forever begin
    @(negedge clk);
    if (cstart === 1'b1) begin
      repeat (20) @(negedge clk);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (90000) @(negedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    wreg(8'h09, 8'h40);
    wreg(8'h00, 8'hff);
    wreg(8'h30, 8'h55);
    for (int i = 0; i < 19; i++) begin
      rreg(RA[151-8*i -: 8], RV[151-8*i -: 8]);
    end
    for (int i = 0; i < 5; i++) begin
      lr = (i == 4) ? 10'sd300 : 10'($random(seed) % 100);
      rr = (i == 4) ? 13'sd4000 : 13'({$random(seed)} % 1024);
      e = rem_exp(rr);
      conv();
      rreg(8'h00, (i == 4) ? 8'h7f : lr[7:0]);
      rreg(8'h01, e[15:8]);
      rreg(8'h10, e[7:0]);
      rreg(8'h10, e[7:0], 1'b0);
    end
    lr = 10'sd25;
    dopen = 1'b1;
    conv();
    rreg(8'h01, 8'h7f);
    rreg(8'h10, 8'h00);
    rreg(8'h02, 8'h16);
    dopen = 1'b0;
    dshort = 1'b1;
    conv();
    rreg(8'h01, 8'h80);
    rreg(8'h02, 8'h08);
    dshort = 1'b0;
    rr = 13'sd528;
    conv();
    rreg(8'h02, 8'h00);
    wreg(8'h09, 8'h41);
    rr = 13'sd768;
    for (int i = 0; i < 3; i++) begin
      conv();
      rreg(8'h02, (i == 2) ? 8'h10 : 8'h00);
    end
    // Steady input through the strongest filter must come out unchanged
    wreg(8'hbf, 8'h06);
    conv();
    rreg(8'h01, 8'h50);
    rr = 13'sd528;
    conv();
    rreg(8'h01, 8'h48);
    rreg(8'h10, 8'h80);
    host.start();
    host.xfer({8'h98, 1'b1}, r9);
    rreg(8'h00, 8'h19);
    host.start();
    host.xfer({8'h99, 1'b1}, r9);
    host.st(1'b0, 1'b0);
    chk_oe(oe, 1'b1);
    repeat (2100) @(negedge clk);
    chk_oe(oe, 1'b0);
    host.stop();
    rreg(8'h00, 8'h19, 1'b0);
    wrap_up();
  end
endmodule // tb_remote_temp_sensor_regs
